// ===== design/tpr_aux_mux.sv
`timescale 1ns/1ps
`include "tpr_defines.svh"
// ----------------------------------------
// Auxiliary pin routing, one per pin
// ----------------------------------------
module tpr_aux_mux (
  input wire logic [3:0] source,
  input wire logic [15:0] signals,
  input wire logic bus_bit,
  output logic level,
  output logic drive
);
  // Code 0 leaves the pin undriven; 1111 gives the bus bit
  always_comb begin
    drive = (source != 4'h0);
    if (source == `TPR_AUX_BUSBIT) begin
      level = bus_bit;
    end else begin
      level = signals[source];
    end
  end
endmodule

// ===== design/tpr_bank.sv
`timescale 1ns/1ps
`include "tpr_defines.svh"
// ----------------------------------------
// Test page register bank, Avalon-MM slave
// ----------------------------------------
module tpr_bank #(
  parameter logic [7:0] VERSION_CODE = 8'h5A // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_host_active,
  input wire logic [5:0] port_pin_in,
  output logic [5:0] port_pin_out,
  output logic [5:0] port_pin_oe,
  input wire logic [255:0] internal_buses,
  input wire logic [15:0] aux_signals,
  output logic aux_pin_one,
  output logic aux_pin_two,
  output logic aux_one_drive,
  output logic aux_two_drive,
  input wire logic checksum_compute_command,
  output logic self_test_enable,
  output logic nonlinear_receive,
  output tpr_pkg::tpr_delim_e delim_mode,
  output logic [3:0] delim_high_trim,
  output logic [3:0] delim_low_trim
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] pin_value_r;
  logic [7:0] self_test_r;
  logic [7:0] aux_sel_r;
  logic [7:0] pin_en_r;
  logic [7:0] obs_sel_r;
  logic [7:0] bit_sel_r;
  logic [7:0] delim_w_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [7:0] rd_nxt;
  logic [7:0] wbyte;
  logic port_io_enable;
  logic [7:0] observed_bus_bits;
  logic wr_go;

  // One wait cycle per access; a write lands on the edge that completes it
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign wbyte = avs_writedata[7:0];
  assign avs_readdata = rdata_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  // Masks drop reserved bits so they never store, except obs_sel_r bits 7..5, which its 8'hFF mask keeps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_value_r <= `TPR_RST_PIN_VALUE;
      self_test_r <= `TPR_RST_SELF_TEST;
      aux_sel_r <= `TPR_RST_AUX_SEL;
      pin_en_r <= `TPR_RST_PIN_EN;
      obs_sel_r <= 8'h00;
      bit_sel_r <= 8'h00;
      delim_w_r <= 8'h00;
    end else if (wr_go) begin
      unique case (avs_address)
        `TPR_IDX_PIN_VALUE: pin_value_r <= wbyte & `TPR_MASK_PIN_VALUE;
        `TPR_IDX_SELF_TEST: self_test_r <= wbyte & `TPR_MASK_SELF_TEST;
        `TPR_IDX_AUX_SEL: aux_sel_r <= wbyte;
        `TPR_IDX_PIN_EN: pin_en_r <= wbyte & `TPR_MASK_PIN_EN;
        `TPR_IDX_OBS_SEL: obs_sel_r <= wbyte & `TPR_MASK_OBS_SEL;
        `TPR_IDX_BIT_SEL: bit_sel_r <= wbyte & `TPR_MASK_BIT_SEL;
        `TPR_IDX_DELIM_W: delim_w_r <= wbyte & `TPR_MASK_DELIM_W;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Test port and observation
  // ----------------------------------------
  // GPIO only while a serial host interface owns the chip
  assign port_io_enable = pin_value_r[`TPR_BIT_IO_USE] & serial_host_active;
  assign port_pin_out = pin_value_r[6:1];
  assign port_pin_oe = port_io_enable ? pin_en_r[6:1] : 6'h00;

  // Slice by five-bit choice of 32 eight-bit buses
  assign observed_bus_bits = internal_buses[obs_sel_r[4:0]*8 +: 8];

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  // Either the code or the checksum command starts self-test
  assign self_test_enable = (self_test_r[3:0] == `TPR_SELF_ON) |
    checksum_compute_command;
  // Threshold shaping lives in the receiver; this flag steers it
  assign nonlinear_receive = self_test_r[`TPR_BIT_AMP];

  tpr_delim u_delim (
    .adjust(self_test_r[`TPR_BIT_ADJ]),
    .width(delim_w_r[0]),
    .mode(delim_mode),
    .high_trim(delim_high_trim),
    .low_trim(delim_low_trim)
  );

  tpr_aux_mux u_aux_pin_one (
    .source(aux_sel_r[7:4]),
    .signals(aux_signals),
    .bus_bit(observed_bus_bits[bit_sel_r[2:0]]),
    .level(aux_pin_one),
    .drive(aux_one_drive)
  );

  tpr_aux_mux u_aux_pin_two (
    .source(aux_sel_r[3:0]),
    .signals(aux_signals),
    .bus_bit(observed_bus_bits[bit_sel_r[2:0]]),
    .level(aux_pin_two),
    .drive(aux_two_drive)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Pin-value read depends on the I/O-use bit; unmapped reads 0
  always_comb begin
    rd_nxt = 8'h00;
    unique case (avs_address)
      `TPR_IDX_PIN_VALUE: begin
        if (pin_value_r[`TPR_BIT_IO_USE]) begin
          rd_nxt = {1'b1, port_pin_in, 1'b0};
        end else begin
          rd_nxt = pin_value_r;
        end
      end
      `TPR_IDX_BUS_VIEW: rd_nxt = observed_bus_bits;
      `TPR_IDX_SELF_TEST: rd_nxt = self_test_r;
      `TPR_IDX_VERSION: rd_nxt = VERSION_CODE;
      `TPR_IDX_AUX_SEL: rd_nxt = aux_sel_r;
      `TPR_IDX_PIN_EN: rd_nxt = pin_en_r;
      `TPR_IDX_OBS_SEL: rd_nxt = obs_sel_r;
      `TPR_IDX_BIT_SEL: rd_nxt = bit_sel_r;
      `TPR_IDX_DELIM_W: rd_nxt = delim_w_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      rdata_r <= {24'h00_0000, rd_nxt};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_io_drive_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !port_io_enable |-> port_pin_oe == 6'h00)
    else $error("pin driven outside I/O mode");
  chk_pin_oe_map: assert property (@(posedge clk) disable iff (sys_rst)
    port_io_enable |-> port_pin_oe == pin_en_r[6:1])
    else $error("pin enable mismatch");
  chk_pin_level: assert property (@(posedge clk) disable iff (sys_rst)
    port_pin_out == pin_value_r[6:1])
    else $error("pin level mismatch");
  chk_live_read: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !ack_r && avs_address == `TPR_IDX_PIN_VALUE &&
    pin_value_r[7] |=> avs_readdata[6:1] == $past(port_pin_in))
    else $error("live pin read wrong");
  chk_stored_read: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !ack_r && avs_address == `TPR_IDX_PIN_VALUE &&
    !pin_value_r[7] |=> avs_readdata[7:0] == $past(pin_value_r))
    else $error("stored pin read wrong");
  chk_version_read: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !ack_r && avs_address == `TPR_IDX_VERSION |=>
    avs_readdata == {24'h00_0000, VERSION_CODE})
    else $error("version read wrong");
  chk_self_test_on: assert property (@(posedge clk) disable iff (sys_rst)
    self_test_r[3:0] == `TPR_SELF_ON |-> self_test_enable)
    else $error("self-test not enabled");
  chk_crc_start: assert property (@(posedge clk) disable iff (sys_rst)
    checksum_compute_command |-> self_test_enable)
    else $error("checksum command missed");
  chk_amp_flag: assert property (@(posedge clk) disable iff (sys_rst)
    nonlinear_receive == self_test_r[6])
    else $error("amplify flag wrong");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    pin_value_r[0] == 1'b0 && self_test_r[7] == 1'b0 && self_test_r[5] == 1'b0)
    else $error("reserved bit stored");
  chk_wait_one: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait length wrong");
  chk_aux_busbit: assert property (@(posedge clk) disable iff (sys_rst)
    aux_sel_r[7:4] == 4'hF |->
    aux_pin_one == observed_bus_bits[bit_sel_r[2:0]])
    else $error("aux bus bit wrong");
  chk_delim_trim: assert property (@(posedge clk) disable iff (sys_rst)
    self_test_r[4] && delim_w_r[0] |-> delim_high_trim == 4'h8 &&
    delim_low_trim == 4'h8)
    else $error("delimiter trim wrong");
  chk_delim_minmax: assert property (@(posedge clk) disable iff (sys_rst)
    !self_test_r[4] |-> delim_mode == (delim_w_r[0] ?
    tpr_pkg::TPR_DELIM_MAX : tpr_pkg::TPR_DELIM_MIN))
    else $error("delimiter mode wrong");
endmodule

// ===== design/tpr_defines.svh
// Contract
// - I/O-use bit turns test port into GPIO (code also requires serial_host_active high)
// - Bits 6..1 drive enabled port pins
// - I/O mode read returns live pin inputs
// - Otherwise read returns stored pin values
// - Test bus view shows selected bus
// - Amplify bit enables non-linear receive processing
// - Non-linear mode makes thresholds act non-linearly
// - Adjust 0, width 1 gives max delimiters
// - Adjust 0, width 0 gives min delimiters
// - Adjust and width 1 give trimmed delimiters
// - Self-check code 1001 enables self-test
// - Checksum command also starts self-test
// - Version register returns fixed silicon code
// - Aux select resets zero, nibbles pick pins
// - Enable bits 6..1 drive matching pins
// - Five-bit field picks observed test bus
// - Aux selector 1111 routes chosen bus bit
`ifndef TPR_DEFINES_SVH
`define TPR_DEFINES_SVH

// ----------------------------------------
// Register addresses (the index itself, unscaled)
// ----------------------------------------
`define TPR_IDX_PIN_VALUE 8'h34
`define TPR_IDX_BUS_VIEW 8'h35
`define TPR_IDX_SELF_TEST 8'h36
`define TPR_IDX_VERSION 8'h37
`define TPR_IDX_AUX_SEL 8'h38
`define TPR_IDX_PIN_EN 8'h33
`define TPR_IDX_OBS_SEL 8'h32
`define TPR_IDX_BIT_SEL 8'h31
`define TPR_IDX_DELIM_W 8'h3E

// ----------------------------------------
// Fields, masks and reset values
// ----------------------------------------
`define TPR_BIT_IO_USE 7
`define TPR_BIT_AMP 6
`define TPR_BIT_ADJ 4
`define TPR_MASK_PIN_VALUE 8'hFE
`define TPR_MASK_SELF_TEST 8'h5F
`define TPR_MASK_PIN_EN 8'hFE
`define TPR_MASK_OBS_SEL 8'hFF
`define TPR_MASK_BIT_SEL 8'h07
`define TPR_MASK_DELIM_W 8'h01
`define TPR_RST_PIN_VALUE 8'h00
`define TPR_RST_SELF_TEST 8'h40
`define TPR_RST_AUX_SEL 8'h00
`define TPR_RST_PIN_EN 8'h80
`define TPR_SELF_ON 4'h9
`define TPR_SELF_OFF 4'h0
`define TPR_AUX_BUSBIT 4'hF
`define TPR_DELIM_TRIM 4'h8

`endif

// ===== design/tpr_delim.sv
`timescale 1ns/1ps
`include "tpr_defines.svh"
// ----------------------------------------
// Delimiter length decode
// ----------------------------------------
module tpr_delim (
  input wire logic adjust,
  input wire logic width,
  output tpr_pkg::tpr_delim_e mode,
  output logic [3:0] high_trim,
  output logic [3:0] low_trim
);
  // Trim counts in clocks: added to SOF high, taken from lows
  always_comb begin
    high_trim = 4'h0;
    low_trim = 4'h0;
    if (!width) begin
      mode = tpr_pkg::TPR_DELIM_MIN;
    end else if (!adjust) begin
      mode = tpr_pkg::TPR_DELIM_MAX;
    end else begin
      mode = tpr_pkg::TPR_DELIM_TRIM;
      high_trim = `TPR_DELIM_TRIM;
      low_trim = `TPR_DELIM_TRIM;
    end
  end
endmodule

// ===== design/tpr_pkg.sv
package tpr_pkg;
  // Delimiter length choice for type B framing
  typedef enum logic [1:0] {
    TPR_DELIM_MIN,
    TPR_DELIM_MAX,
    TPR_DELIM_TRIM
  } tpr_delim_e;
  typedef logic [7:0] tpr_byte_t;
endpackage

// ===== verification/test_page_register_bank_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module test_page_register_bank_tb_top;
  localparam logic [7:0] VER = 8'h3C; // Arbitrary value
  logic clk = 1'b0;
  logic sys_rst, avs_read, avs_write, serial_host_active, cmd;
  logic [7:0] avs_address, eb;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, aux_pin_one, aux_pin_two;
  logic aux_one_drive, aux_two_drive, self_test_enable, nonlinear_receive;
  logic [5:0] port_pin_in, port_pin_out, port_pin_oe;
  logic [255:0] internal_buses;
  logic [15:0] aux_signals;
  tpr_pkg::tpr_delim_e delim_mode;
  logic [3:0] delim_high_trim, delim_low_trim;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  tpr_host_model tpr_host_model_inst (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .checksum_compute_command(cmd));

  tpr_bank #(.VERSION_CODE(VER)) tpr_bank_inst (.clk(clk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_host_active(serial_host_active), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .internal_buses(internal_buses), .aux_signals(aux_signals),
    .aux_pin_one(aux_pin_one), .aux_pin_two(aux_pin_two),
    .aux_one_drive(aux_one_drive), .aux_two_drive(aux_two_drive),
    .checksum_compute_command(cmd), .self_test_enable(self_test_enable),
    .nonlinear_receive(nonlinear_receive), .delim_mode(delim_mode),
    .delim_high_trim(delim_high_trim), .delim_low_trim(delim_low_trim));

  // Clock and hang guard; tests need well under 2000 cycles
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] bv(input int n);
    return 8'(n * 9 + 1);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    tpr_host_model_inst.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    tpr_host_model_inst.xfer(1'b0, a, 8'h00, q);
  endtask

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] q;
    sys_rst = 1'b1;
    serial_host_active = 1'b0;
    port_pin_in = 6'h00;
    aux_signals = 16'hA5C3;
    for (int n = 0; n < 32; n++) internal_buses[8*n+:8] = bv(n);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h34, q); chk(q, 8'h00);
    rd(8'h36, q); chk(q, 8'h40);
    rd(8'h38, q); chk(q, 8'h00);
    chk({7'h00, nonlinear_receive}, 8'h01);
    chk({6'h00, aux_one_drive, aux_two_drive}, 8'h00);
    wr(8'h37, 8'hFF);
    rd(8'h37, q); chk(q, VER);
    rd(8'h30, q); chk(q, 8'h00);
    wr(8'h34, 8'h7F);
    rd(8'h34, q); chk(q, 8'h7E);
    chk({2'b00, port_pin_oe}, 8'h00);
    wr(8'h33, 8'h2A);
    wr(8'h34, 8'hD4);
    chk({2'b00, port_pin_oe}, 8'h00);
    // Host interface goes active with pins held differently
    @(posedge clk);
    serial_host_active <= 1'b1;
    port_pin_in <= 6'h33;
    @(negedge clk);
    chk({2'b00, port_pin_oe}, 8'h15);
    chk({2'b00, port_pin_out}, 8'h2A);
    rd(8'h34, q); chk(q, 8'hE6);
    wr(8'h34, 8'h54);
    rd(8'h34, q); chk(q, 8'h54);
    chk({2'b00, port_pin_oe}, 8'h00);
    foreach (eb[i]) begin
      wr(8'h32, 8'(i * 4 + 3));
      rd(8'h35, q); chk(q, bv(i * 4 + 3));
    end
    wr(8'h36, 8'h09);
    chk({6'h00, self_test_enable, nonlinear_receive}, 8'h02);
    tpr_host_model_inst.normal_mode();
    chk({7'h00, self_test_enable}, 8'h00);
    tpr_host_model_inst.crc_cmd(1'b1);
    @(negedge clk);
    chk({7'h00, self_test_enable}, 8'h01);
    tpr_host_model_inst.crc_cmd(1'b0);
    wr(8'h36, 8'hFF);
    rd(8'h36, q); chk(q, 8'h5F);
    wr(8'h3E, 8'h01);
    wr(8'h36, 8'h00);
    chk(8'(delim_mode), 8'(tpr_pkg::TPR_DELIM_MAX));
    wr(8'h3E, 8'h00);
    chk(8'(delim_mode), 8'(tpr_pkg::TPR_DELIM_MIN));
    wr(8'h36, 8'h10);
    wr(8'h3E, 8'h01);
    chk(8'(delim_mode), 8'(tpr_pkg::TPR_DELIM_TRIM));
    chk({delim_high_trim, delim_low_trim}, 8'h88);
    wr(8'h31, 8'h03);
    wr(8'h32, 8'h05);
    for (int c = 1; c < 15; c++) begin
      wr(8'h38, {4'(c), 4'h0});
      chk({aux_two_drive, aux_one_drive, aux_pin_one},
          {5'h00, 2'b01, aux_signals[c]});
    end
    wr(8'h38, 8'h0F);
    eb = bv(5);
    chk({6'h00, aux_two_drive, aux_pin_two}, {6'h00, 1'b1, eb[3]});
    conclude();
  end
endmodule

// ===== verification/tpr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side: register master and commands
// ----------------------------------------
module tpr_host_model (
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic checksum_compute_command,
  input wire logic clk,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus from time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    checksum_compute_command = 1'b0;
  end

  // One access; held until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let the write settle before callers look at outputs
    @(negedge clk);
  endtask

  // Normal running leaves the self-check code cleared
  task automatic normal_mode();
    logic [7:0] q;
    xfer(1'b1, 8'h36, 8'h40, q);
  endtask

  // Checksum command level, changed just after an edge
  task automatic crc_cmd(input logic v);
    @(posedge clk);
    checksum_compute_command <= v;
  endtask
endmodule
